// ===== common/rboh_defines.svh
`ifndef RBOH_DEFINES_SVH
`define RBOH_DEFINES_SVH

// Opcodes handled by this block
`define RBOH_OP_SIGNALLING_INFO  8'h25
`define RBOH_OP_SHOW_BUTTON      8'h09
`define RBOH_OP_SQUELCH_DETECT   8'h1E
`define RBOH_OP_CODED_SQL_DETECT 8'h1F
`define RBOH_OP_SQUELCH_VALUE    8'h28
`define RBOH_OP_SYSTEM_STATUS    8'h4D
`define RBOH_OP_TALKBACK_SWITCH  8'h31
`define RBOH_OP_TIME_UPDATE      8'h4E
`define RBOH_OP_TIMEOUT_LIMIT    8'h36

// Flag bit positions inside the flag field
`define RBOH_FLAG_D1 0
`define RBOH_FLAG_D2 1
`define RBOH_FLAG_D3 2

// Wishbone register byte offsets
`define RBOH_REG_CTRL      8'h00
`define RBOH_REG_STATUS    8'h04
`define RBOH_REG_SYS_WORD  8'h08
`define RBOH_REG_TIME      8'h0C
`define RBOH_REG_OPERATOR  8'h10
`define RBOH_REG_EFFECTIVE 8'h14

// Control register fields
`define RBOH_CTRL_TIME_SEND   0
`define RBOH_CTRL_STATUS_SEND 1
`define RBOH_CTRL_TRUNKED     2
`define RBOH_CTRL_SCAN_ON     3

// Reset values
`define RBOH_SQUELCH_RESET  4'h8
`define RBOH_TIMEOUT_RESET  8'h0C
`define RBOH_TALKBACK_RESET 1'b1

// Transmit timer: one tick per 5 s interval at 20 MHz
`define RBOH_CLK_HZ        20000000
`define RBOH_INTERVAL_S    5
`define RBOH_INTERVAL_CYC  (`RBOH_CLK_HZ * `RBOH_INTERVAL_S)

`endif

// ===== common/rboh_pkg.sv
package rboh_pkg;

    // Decoded bus message: opcode, D1..D3 flags, up to five data bytes
    typedef struct packed {
        logic [7:0]      opcode;
        logic            request;
        logic [2:0]      flags;
        logic [4:0][7:0] data;
    } rboh_msg_type;

    // Wishbone classic request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } rboh_wb_req_type;

    // Transmit message sequencer
    typedef enum logic [2:0] {
        RBOH_IDLE   = 3'b000,
        RBOH_SEND   = 3'b001,
        RBOH_WAIT   = 3'b011,
        RBOH_NEXT   = 3'b010
    } rboh_tx_state_type;

endpackage : rboh_pkg

// ===== hdl/rboh_opcode_handler.sv
`timescale 1ns/10ps
`include "rboh_defines.svh"

// Function
// - Broadcast payload bytes, index from one
// - Payload only, no coding, no end marker
// - Hold request bytes until complete
// - Broadcast squelch detect on carrier change
// - Flags: long carrier present, audio detect
// - Same audio detect in coded squelch message
// - Apply squelch override, keep operator value
// - Squelch level zero open, F tight
// - Squelch override reverts on reset or mode
// - No restore flag: operator squelch
// - Status word broadcast on send bit, change flagged with scan on
// - Conventional: all seventeen status bits zero
// - Talkback override from third flag, operator kept
// - Talkback override revert conditions
// - Radio alone broadcasts time update, no address
// - Time flags and binary hour minute second
// - New timeout limit immediate, expire if exceeded
// - Limit in five second intervals, zero infinite
// - Timeout override reverts on dekey, mode, reset
// - No restore flag: operator limit
module rboh_opcode_handler
    import rboh_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // Wishbone slave
    input  wire rboh_wb_req_type wb_req,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    // Decoded messages from bus receiver
    input  wire logic            rx_valid,
    input  wire rboh_msg_type    rx_msg,
    output logic                 rx_ready,
    // Messages to bus transmitter
    output logic                 tx_valid,
    output rboh_msg_type         tx_msg,
    input  wire logic            tx_ready,
    // Signalling decoder: received payload bytes
    input  wire logic            sig_valid,
    input  wire logic [7:0]      sig_byte,
    input  wire logic            sig_last,
    output logic                 sig_ready,
    // Signalling encoder: request payload to radio
    output logic                 rf_valid,
    output logic [7:0]           rf_byte,
    output logic [7:0]           rf_count,
    input  wire logic            rf_ready,
    // Radio state
    input  wire logic            carrier_long,
    input  wire logic            audio_detect,
    input  wire logic            active_mode_change,
    input  wire logic            tx_keyed,
    // Effective settings
    output logic [3:0]           squelch_level,
    output logic                 talkback_on,
    output logic                 timeout_expired
);

    // Request payload store depth
    localparam int unsigned BUF_DEPTH = 32;

    // Decoded register access
    wire        wb_hit      = wb_req.cyc && wb_req.stb && !wb_ack_o;
    wire        wb_wr       = wb_hit && wb_req.we && wb_req.sel[0];
    wire        wr_ctrl     = wb_wr && (wb_req.adr == `RBOH_REG_CTRL);
    wire        wr_sys      = wb_wr && (wb_req.adr == `RBOH_REG_SYS_WORD);
    wire        wr_time     = wb_wr && (wb_req.adr == `RBOH_REG_TIME);
    wire        wr_oper     = wb_wr && (wb_req.adr == `RBOH_REG_OPERATOR);

    // Incoming opcode decode
    wire        rx_take     = rx_valid && rx_ready;
    wire        op_sql_val  = rx_take && (rx_msg.opcode == `RBOH_OP_SQUELCH_VALUE);
    wire        op_tb       = rx_take && (rx_msg.opcode == `RBOH_OP_TALKBACK_SWITCH);
    wire        op_tot      = rx_take && (rx_msg.opcode == `RBOH_OP_TIMEOUT_LIMIT);
    wire        op_sig_req  = rx_take && (rx_msg.opcode == `RBOH_OP_SIGNALLING_INFO)
                              && rx_msg.request;
    wire        f_d1        = rx_msg.flags[`RBOH_FLAG_D1];
    wire        f_d2        = rx_msg.flags[`RBOH_FLAG_D2];
    wire        f_d3        = rx_msg.flags[`RBOH_FLAG_D3];

    // Registers
    logic [3:0] ctrl;
    logic [16:0] sys_word;
    logic [31:0] time_word;
    logic [3:0]  oper_squelch;
    logic        oper_talkback;
    logic [7:0]  oper_timeout;
    logic [3:0]  ovr_squelch;
    logic [1:0]  ovr_squelch_mode;
    logic        ovr_talkback;
    logic [1:0]  ovr_talkback_mode;
    logic [7:0]  ovr_timeout;
    logic [1:0]  ovr_timeout_mode;
    logic        send_time_done;
    logic        send_status_done;

    // Show-button, foreign squelch-detect ignored
    assign rx_ready = 1'b1;

    // Software registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl          <= 4'h0;
            sys_word      <= 17'h00000;
            time_word     <= 32'h00000000;
            oper_squelch  <= `RBOH_SQUELCH_RESET;
            oper_talkback <= `RBOH_TALKBACK_RESET;
            oper_timeout  <= `RBOH_TIMEOUT_RESET;
        end else begin
            if (wr_ctrl)
                ctrl <= wb_req.dat[3:0];
            else
                ctrl[1:0] <= ctrl[1:0] & ~{send_status_done, send_time_done};
            if (wr_sys)
                sys_word <= wb_req.dat[16:0];
            if (wr_time)
                time_word <= wb_req.dat;
            if (wr_oper) begin
                oper_squelch  <= wb_req.dat[3:0];
                oper_talkback <= wb_req.dat[4];
                oper_timeout  <= wb_req.dat[15:8];
            end
        end
    end

    // Revert mode: 0 none, 1 reset only, 2 mode change, also dekey for timeout
    function automatic logic [1:0] ovr_mode(input logic d1, input logic d2);
        ovr_mode = d2 ? 2'd2 : (d1 ? 2'd1 : 2'd0);
    endfunction : ovr_mode

    // De-key edge
    logic tx_keyed_q;
    wire  dekey = tx_keyed_q && !tx_keyed;

    // Option overrides, operator values kept
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ovr_squelch       <= 4'h0;
            ovr_squelch_mode  <= 2'd0;
            ovr_talkback      <= 1'b0;
            ovr_talkback_mode <= 2'd0;
            ovr_timeout       <= 8'h00;
            ovr_timeout_mode  <= 2'd0;
            tx_keyed_q        <= 1'b0;
        end else begin
            tx_keyed_q <= tx_keyed;
            if (op_sql_val) begin
                ovr_squelch      <= rx_msg.data[2][3:0];
                ovr_squelch_mode <= ovr_mode(f_d1, f_d2);
            end else if (active_mode_change && ovr_squelch_mode == 2'd2)
                ovr_squelch_mode <= 2'd0;
            if (op_tb) begin
                ovr_talkback      <= f_d3;
                ovr_talkback_mode <= ovr_mode(f_d1, f_d2);
            end else if (active_mode_change && ovr_talkback_mode == 2'd2)
                ovr_talkback_mode <= 2'd0;
            if (op_tot) begin
                ovr_timeout      <= rx_msg.data[2];
                ovr_timeout_mode <= ovr_mode(f_d1, f_d2);
            end else if ((active_mode_change || dekey) && ovr_timeout_mode == 2'd2)
                ovr_timeout_mode <= 2'd0;
        end
    end

    // Effective settings
    wire [7:0] tot_limit = (ovr_timeout_mode != 2'd0) ? ovr_timeout : oper_timeout;
    always_comb begin
        squelch_level = (ovr_squelch_mode != 2'd0) ? ovr_squelch : oper_squelch;
        talkback_on   = (ovr_talkback_mode != 2'd0) ? ovr_talkback : oper_talkback;
    end

    // Transmit timer counts whole 5 s intervals while keyed
    logic [31:0] tick_cnt;
    logic [7:0]  tot_elapsed;
    wire         tick = (tick_cnt == 32'(`RBOH_INTERVAL_CYC - 1));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt    <= 32'h00000000;
            tot_elapsed <= 8'h00;
        end else if (!tx_keyed) begin
            tick_cnt    <= 32'h00000000;
            tot_elapsed <= 8'h00;
        end else begin
            tick_cnt <= tick ? 32'h00000000 : tick_cnt + 32'h00000001;
            if (tick && tot_elapsed != 8'hFF)
                tot_elapsed <= tot_elapsed + 8'h01;
        end
    end
    // Live limit, so a lower limit expires at once
    assign timeout_expired = tx_keyed && (tot_limit != 8'h00)
                             && (tot_elapsed >= tot_limit);

    // Request payload buffer toward the signalling encoder
    logic [7:0] req_buf [BUF_DEPTH];
    logic [7:0] req_len;
    logic [7:0] req_rd;
    logic       req_busy;
    // First byte gives total length
    wire  [7:0] req_idx  = rx_msg.data[0];
    wire        req_full = (req_len != 8'h00) && (req_idx == req_len);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            req_len  <= 8'h00;
            req_rd   <= 8'h00;
            req_busy <= 1'b0;
        end else if (req_busy) begin
            if (rf_ready) begin
                if (req_rd + 8'h01 == req_len) begin
                    req_busy <= 1'b0;
                    req_len  <= 8'h00;
                    req_rd   <= 8'h00;
                end else
                    req_rd <= req_rd + 8'h01;
            end
        end else if (op_sig_req && req_idx != 8'h00 && req_idx <= 8'(BUF_DEPTH)) begin
            if (req_idx == 8'h01)
                req_len <= rx_msg.data[1];
            if (req_full || (req_idx == 8'h01 && rx_msg.data[1] == 8'h01))
                req_busy <= 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (op_sig_req && !req_busy && req_idx != 8'h00 && req_idx <= 8'(BUF_DEPTH))
            req_buf[5'(req_idx - 8'h01)] <= rx_msg.data[1];
    end
    assign rf_valid = req_busy;
    assign rf_byte  = req_buf[5'(req_rd)];
    assign rf_count = req_len;

    // Carrier and audio change detection
    logic carrier_q;
    logic audio_q;
    logic sql_pend;
    logic pl_pend;
    wire  sql_change = (carrier_q != carrier_long) || (audio_q != audio_detect);
    wire  audio_change = audio_q != audio_detect;

    // Outgoing message arbitration
    rboh_tx_state_type state;
    rboh_tx_state_type next_state;
    logic [7:0]        sig_seq;
    logic              sig_pend;
    logic [7:0]        sig_hold;
    logic              sig_hold_last;

    assign sig_ready = !sig_pend;
    assign tx_valid  = (state == RBOH_SEND);

    // Priority order
    wire sel_sql  = sql_pend;
    wire sel_pl   = !sel_sql && pl_pend;
    wire sel_sig  = !sel_sql && !sel_pl && sig_pend;
    wire sel_stat = !sel_sql && !sel_pl && !sel_sig && ctrl[`RBOH_CTRL_STATUS_SEND];
    wire sel_time = !sel_sql && !sel_pl && !sel_sig && !sel_stat
                    && ctrl[`RBOH_CTRL_TIME_SEND];
    wire any_sel  = sel_sql || sel_pl || sel_sig || sel_stat || sel_time;
    wire tx_done  = (state == RBOH_SEND) && tx_ready;

    assign send_time_done   = tx_done && (tx_msg.opcode == `RBOH_OP_TIME_UPDATE);
    assign send_status_done = tx_done && (tx_msg.opcode == `RBOH_OP_SYSTEM_STATUS);

    // Zero word when conventional
    wire [16:0] status_out = ctrl[`RBOH_CTRL_TRUNKED] ? sys_word : 17'h00000;

    always_comb begin
        case (state)
            RBOH_IDLE: next_state = any_sel ? RBOH_NEXT : RBOH_IDLE;
            RBOH_NEXT: next_state = RBOH_SEND;
            RBOH_SEND: next_state = tx_ready ? RBOH_WAIT : RBOH_SEND;
            RBOH_WAIT: next_state = RBOH_IDLE;
            default:   next_state = RBOH_IDLE;
        endcase
    end

    // Last status word sent
    logic [16:0] last_status;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= RBOH_IDLE;
            tx_msg      <= '0;
            carrier_q   <= 1'b0;
            audio_q     <= 1'b0;
            sql_pend    <= 1'b0;
            pl_pend     <= 1'b0;
            sig_pend    <= 1'b0;
            sig_hold    <= 8'h00;
            sig_hold_last <= 1'b0;
            sig_seq     <= 8'h00;
            last_status <= 17'h00000;
        end else begin
            state     <= next_state;
            carrier_q <= carrier_long;
            audio_q   <= audio_detect;
            // Set wins over clear
            if (sql_change)
                sql_pend <= 1'b1;
            else if (state == RBOH_IDLE && sel_sql)
                sql_pend <= 1'b0;
            if (audio_change)
                pl_pend <= 1'b1;
            else if (state == RBOH_IDLE && sel_pl)
                pl_pend <= 1'b0;
            if (sig_valid && !sig_pend) begin
                sig_pend <= 1'b1;
                sig_hold <= sig_byte;
                sig_hold_last <= sig_last;
            end else if (state == RBOH_IDLE && sel_sig)
                sig_pend <= 1'b0;
            if (state == RBOH_IDLE && any_sel) begin
                tx_msg <= '0;
                if (sel_sql) begin
                    tx_msg.opcode <= `RBOH_OP_SQUELCH_DETECT;
                    tx_msg.flags  <= {1'b0, audio_q, carrier_q};
                end else if (sel_pl) begin
                    tx_msg.opcode <= `RBOH_OP_CODED_SQL_DETECT;
                    tx_msg.flags  <= {1'b0, audio_q, 1'b0};
                end else if (sel_sig) begin
                    tx_msg.opcode  <= `RBOH_OP_SIGNALLING_INFO;
                    tx_msg.request <= 1'b0;
                    tx_msg.data[0] <= sig_seq + 8'h01;
                    tx_msg.data[1] <= sig_hold;
                    sig_seq        <= sig_hold_last ? 8'h00 : sig_seq + 8'h01;
                end else if (sel_stat) begin
                    tx_msg.opcode  <= `RBOH_OP_SYSTEM_STATUS;
                    tx_msg.flags   <= {2'b00, status_out[16]};
                    tx_msg.data[0] <= status_out[15:8];
                    tx_msg.data[1] <= status_out[7:0];
                    last_status    <= status_out;
                end else begin
                    tx_msg.opcode  <= `RBOH_OP_TIME_UPDATE;
                    tx_msg.flags   <= time_word[26:24];
                    tx_msg.data[0] <= {3'b000, time_word[20:16]};
                    tx_msg.data[1] <= time_word[15:8];
                    tx_msg.data[2] <= time_word[7:0];
                end
            end
        end
    end

    // Status word changed under scan
    wire status_stale = ctrl[`RBOH_CTRL_SCAN_ON] && (status_out != last_status);

    // Register read mux
    always_comb begin
        case (wb_req.adr)
            `RBOH_REG_CTRL:      wb_dat_o = {28'h0000000, ctrl};
            `RBOH_REG_STATUS:    wb_dat_o = {16'h0000, tot_elapsed, 3'b000, status_stale,
                                             req_busy, timeout_expired, audio_q, carrier_q};
            `RBOH_REG_SYS_WORD:  wb_dat_o = {15'h0000, sys_word};
            `RBOH_REG_TIME:      wb_dat_o = time_word;
            `RBOH_REG_OPERATOR:  wb_dat_o = {16'h0000, oper_timeout, 3'b000, oper_talkback,
                                             oper_squelch};
            `RBOH_REG_EFFECTIVE: wb_dat_o = {16'h0000, tot_limit, 3'b000, talkback_on,
                                             squelch_level};
            default:             wb_dat_o = 32'h00000000;
        endcase
    end

    // One-cycle ack, unmapped reads zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_hit;
    end

endmodule : rboh_opcode_handler

// ===== dv/rboh_opcode_handler_sva.sv
`timescale 1ns/10ps
`include "rboh_defines.svh"

module rboh_opcode_handler_sva
    import rboh_pkg::*;
(
    // Clock and reset
    input wire logic            clk,
    input wire logic            arst_n,
    // Register bus
    input wire rboh_wb_req_type wb_req,
    input wire logic            wb_ack_o,
    // Message handshakes
    input wire logic            rx_valid,
    input wire rboh_msg_type    rx_msg,
    input wire logic            rx_ready,
    input wire logic            tx_valid,
    input wire rboh_msg_type    tx_msg,
    input wire logic            tx_ready,
    input wire logic            rf_valid,
    input wire logic [7:0]      rf_byte,
    input wire logic            rf_ready,
    // Radio state and settings
    input wire logic            carrier_long,
    input wire logic            audio_detect,
    input wire logic [3:0]      squelch_level,
    input wire logic            talkback_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Decoded causes
    wire req_new = wb_req.cyc && wb_req.stb && !wb_ack_o;
    wire sq_ovr  = rx_valid && rx_msg.opcode == `RBOH_OP_SQUELCH_VALUE && rx_msg.flags[1:0] != 2'h0;
    wire tb_ovr  = rx_valid && rx_msg.opcode == `RBOH_OP_TALKBACK_SWITCH && rx_msg.flags[1:0] != 2'h0;
    wire tx_op_1e = tx_valid && tx_msg.opcode == `RBOH_OP_SQUELCH_DETECT;

    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_req; req_new |=> wb_ack_o; endproperty
    a_ack_req: assert property (p_ack_req) else $error("no ack");
    property p_rx_ready; rx_ready; endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("rx refused");
    property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_msg); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx msg unstable");
    property p_rf_hold; rf_valid && !rf_ready |=> rf_valid && $stable(rf_byte); endproperty
    a_rf_hold: assert property (p_rf_hold) else $error("payload byte dropped");
    property p_sqd_evt; $changed(carrier_long) |-> ##[1:40] tx_op_1e; endproperty
    a_sqd_evt: assert property (p_sqd_evt) else $error("no squelch detect");
    property p_sqd_flags; tx_op_1e |-> tx_msg.flags[1:0] == {audio_detect, carrier_long}; endproperty
    a_sqd_flags: assert property (p_sqd_flags) else $error("sqd flags");
    property p_csq_flag;
        tx_valid && tx_msg.opcode == `RBOH_OP_CODED_SQL_DETECT |-> tx_msg.flags[1] == audio_detect;
    endproperty
    a_csq_flag: assert property (p_csq_flag) else $error("csq flag");
    property p_sq_val; sq_ovr |-> ##2 squelch_level == $past(rx_msg.data[2][3:0], 2); endproperty
    a_sq_val: assert property (p_sq_val) else $error("squelch ovr");
    property p_tb_val; tb_ovr |-> ##2 talkback_on == $past(rx_msg.flags[2], 2); endproperty
    a_tb_val: assert property (p_tb_val) else $error("talkback ovr");
    property p_info_bc;
        tx_valid && tx_msg.opcode == `RBOH_OP_SIGNALLING_INFO |-> !tx_msg.request;
    endproperty
    a_info_bc: assert property (p_info_bc) else $error("info not broadcast");

    // Main scenarios reached
    c_info: cover property (tx_valid && tx_ready && tx_msg.opcode == `RBOH_OP_SIGNALLING_INFO);
    c_rf: cover property (rf_valid && rf_ready);
    c_sq: cover property (sq_ovr);
endmodule : rboh_opcode_handler_sva

// ===== dv/rboh_far_side.sv
`timescale 1ns/10ps

module rboh_far_side
    import rboh_pkg::*;
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         arst_n,
    // Bus transmitter
    input  wire logic         tx_valid,
    input  wire rboh_msg_type tx_msg,
    output logic              tx_ready,
    // Signalling encoder
    input  wire logic         rf_valid,
    input  wire logic [7:0]   rf_byte,
    output logic              rf_ready,
    // Slow acceptance
    input  wire logic         slow
);
    rboh_msg_type msg_q[$];
    logic [7:0]   byte_q[$];
    logic [1:0]   wait_cnt;

    // One message per handshake, late when slow
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_ready <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (tx_valid && tx_ready) begin
            msg_q.push_back(tx_msg);
            tx_ready <= 1'b0;
            wait_cnt <= slow ? 2'h3 : 2'h0;
        end else if (tx_valid && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else begin
            tx_ready <= tx_valid;
        end
    end

    // Encoder stalls every other cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rf_ready <= 1'b0;
        end else begin
            if (rf_valid && rf_ready) begin
                byte_q.push_back(rf_byte);
            end
            rf_ready <= rf_valid && !rf_ready;
        end
    end
endmodule : rboh_far_side

// ===== dv/rboh_opcode_handler_tb_top.sv
`timescale 1ns/10ps
`include "rboh_defines.svh"
`define TB_CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module rboh_opcode_handler_tb_top
    import rboh_pkg::*;
;
    logic            clk, arst_n, wb_ack_o, rx_valid, rx_ready, tx_valid, tx_ready, slow;
    logic            sig_valid, sig_last, sig_ready, rf_valid, rf_ready, carrier_long;
    logic            audio_detect, active_mode_change, tx_keyed, talkback_on, timeout_expired;
    logic [7:0]      sig_byte, rf_byte, rf_count;
    logic [3:0]      squelch_level;
    logic [31:0]     wb_dat_o, rd;
    rboh_wb_req_type wb_req;
    rboh_msg_type    rx_msg, tx_msg, m;
    int              n_fail = 0;
    int              samples_checked = 0;
    int              cycles = 0;
    logic [7:0]      sb [3] = '{8'hA5, 8'h3C, 8'h0F};
    logic [7:0]      rq [3] = '{8'h03, 8'h77, 8'h99};
    // Opcode, flags, event, value, expected settings
    logic [39:0]     tbl [14] = '{40'h28_2_0_0F_0C1F, 40'h00_0_1_00_0C18, 40'h28_1_1_00_0C10,
        40'h28_0_0_05_0C18, 40'h31_2_0_00_0C08, 40'h00_0_1_00_0C18, 40'h31_1_1_00_0C08,
        40'h31_0_0_00_0C18, 40'h36_2_0_00_0018, 40'h00_0_2_00_0C18, 40'h36_1_3_05_0518,
        40'h36_0_0_09_0C18, 40'h09_0_0_03_0C18, 40'h1E_3_0_00_0C18};

    rboh_opcode_handler DUT (.clk, .arst_n, .wb_req, .wb_dat_o, .wb_ack_o, .rx_valid, .rx_msg,
        .rx_ready, .tx_valid, .tx_msg, .tx_ready, .sig_valid, .sig_byte, .sig_last, .sig_ready,
        .rf_valid, .rf_byte, .rf_count, .rf_ready, .carrier_long, .audio_detect,
        .active_mode_change, .tx_keyed, .squelch_level, .talkback_on, .timeout_expired);
    rboh_far_side far (.clk, .arst_n, .tx_valid, .tx_msg, .tx_ready, .rf_valid, .rf_byte,
        .rf_ready, .slow);

    // Clock and hang guard
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    // Held until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
    endtask : wb_cycle

    task automatic send_rx(input logic [7:0] op, input logic [2:0] fl, input logic [7:0] d0,
                           input logic [7:0] d1, input logic [7:0] d2, input logic req);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_msg   <= '{opcode: op, request: req, flags: fl, data: {16'h0, d2, d1, d0}};
        @(posedge clk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send_rx

    // Bit 0 mode change, bit 1 key and de-key
    task automatic radio_event(input logic [3:0] ev);
        @(posedge clk);
        active_mode_change <= ev[0];
        tx_keyed <= ev[1];
        @(posedge clk);
        active_mode_change <= 1'b0;
        repeat (2) @(posedge clk);
        tx_keyed <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : radio_event

    task automatic wait_msg(input logic [7:0] op);
        do begin
            while (far.msg_q.size() == 0) @(posedge clk);
            m = far.msg_q.pop_front();
        end while (m.opcode !== op);
    endtask : wait_msg

    initial begin
        {clk, arst_n, rx_valid, sig_valid, sig_last, carrier_long, audio_detect} = '0;
        {active_mode_change, tx_keyed, slow, sig_byte, wb_req, rx_msg} = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        `TB_CHK({squelch_level, talkback_on, timeout_expired}, 6'h22)
        wb_cycle(1'b0, `RBOH_REG_OPERATOR, 32'h0);
        `TB_CHK(rd, 32'h0000_0C18)
        wb_cycle(1'b0, 8'h3C, 32'h0);
        `TB_CHK(rd, 32'h0)
        $display("test reset finished");
        foreach (tbl[i]) begin
            if (tbl[i][39:32] != 8'h00) begin
                send_rx(tbl[i][39:32], tbl[i][30:28], 8'h00, 8'h00, tbl[i][23:16], 1'b0);
            end
            radio_event(tbl[i][27:24]);
            wb_cycle(1'b0, `RBOH_REG_EFFECTIVE, 32'h0);
            `TB_CHK(rd, {16'h0, tbl[i][15:0]})
        end
        `TB_CHK(far.msg_q.size(), 0)
        $display("test overrides finished");
        slow <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            carrier_long <= 1'b1;
            audio_detect <= (i == 0);
            wait_msg(`RBOH_OP_SQUELCH_DETECT);
            `TB_CHK(m.flags[1:0], {i == 0, 1'b1})
            wait_msg(`RBOH_OP_CODED_SQL_DETECT);
            `TB_CHK(m.flags[1], (i == 0))
        end
        $display("test squelch detect finished");
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            sig_valid <= 1'b1;
            sig_byte  <= sb[i];
            sig_last  <= (i == 2);
            do @(posedge clk); while (sig_ready !== 1'b1);
            sig_valid <= 1'b0;
        end
        for (int i = 0; i < 3; i++) begin
            wait_msg(`RBOH_OP_SIGNALLING_INFO);
            `TB_CHK({m.request, m.data[0], m.data[1]}, {1'b0, 8'(i + 1), sb[i]})
        end
        repeat (30) @(posedge clk);
        `TB_CHK(far.msg_q.size(), 0)
        for (int i = 0; i < 3; i++) begin
            if (i == 2) `TB_CHK(far.byte_q.size(), 0)
            send_rx(`RBOH_OP_SIGNALLING_INFO, 3'h0, 8'(i + 1), rq[i], 8'h00, 1'b1);
        end
        repeat (30) @(posedge clk);
        `TB_CHK(far.byte_q.size(), 3)
        foreach (rq[i]) `TB_CHK(far.byte_q[i], rq[i])
        $display("test signalling finished");
        wb_cycle(1'b1, `RBOH_REG_SYS_WORD, 32'h0001_BEEF);
        wb_cycle(1'b1, `RBOH_REG_CTRL, 32'h0000_000E);
        wait_msg(`RBOH_OP_SYSTEM_STATUS);
        `TB_CHK({m.flags[0], m.data[0], m.data[1]}, 17'h1BEEF)
        repeat (30) @(posedge clk);
        far.msg_q.delete();
        wb_cycle(1'b1, `RBOH_REG_CTRL, 32'h0000_0002);
        wait_msg(`RBOH_OP_SYSTEM_STATUS);
        `TB_CHK({m.flags[0], m.data[0], m.data[1]}, 17'h0)
        $display("test status finished");
        wb_cycle(1'b1, `RBOH_REG_TIME, 32'h020D_1E2D);
        wb_cycle(1'b1, `RBOH_REG_CTRL, 32'h0000_0001);
        wait_msg(`RBOH_OP_TIME_UPDATE);
        `TB_CHK({m.request, m.flags, m.data[0], m.data[1], m.data[2]}, 28'h20D1E2D)
        wb_cycle(1'b0, `RBOH_REG_CTRL, 32'h0);
        `TB_CHK(rd, 32'h0)
        $display("test time finished");
        close_out();
    end
endmodule : rboh_opcode_handler_tb_top

bind rboh_opcode_handler rboh_opcode_handler_sva u_sva (.*);
